// file: core/mss_starter.sv
// motor starter status, process image and indicator logic
// assumes pins are asynchronous to clock; motor_current comes from same-clock logic
//
// What this block does
// R1: flash indicators at 0.5 Hz, flicker patterns at 8 to 10 Hz
// R2: group-error indicator shows its patterns only with group diagnostics enabled
// R3: safety-group indicator dark when unconfigured and emergency stop present
// R4: flash green when no stop and unconfigured, or stop and configured
// R5: steady green when configured and no emergency stop
// R6: self test on newer hardware: red, yellow, yellow, running light
// R7: configured group differs from selected bus: two indicators flash together
// R8: running light over all safety-group indicators on decoder fault
// R9: brake indicator yellow while released, off while applied
// R10: clockwise limit active: its indicator off, other green, brake applied
// R11: counter-clockwise limit active: its indicator off, other green, brake applied
// R12: brake overload: group error red, brake indicator yellow
// R13: bus fault: group error red, brake follows configured fault reaction
// R14: limit-switch inputs are normally closed; open contact means activated
// R15: input bit 0.0 is 1 when ready, 0 when contactor jammed
// R16: input bit 0.1 is contactor feedback, either direction
// R17: input bit 0.2 is 1 once breaker tripped; bit 0.3 unused
// R18: controller sets output bits 0.0 and 0.1 to run each direction
// R19: output bit 0.2 releases the brake when 1
// R20: input bit 1.6 reads 1 during local manual operation
// R21: motor current as six-bit field in input byte 1 bits 0 to 5
// R22: all blink timing from one reset-cleared free-running divider
// R23: trip reset only on rising edge of output bit 0.3
`timescale 1ns/1ns
`default_nettype none

module mss_starter
	import mss_pkg::*;
#(
	parameter int NUM_GROUPS = 4,
	parameter int FLICKER_HALF = FLICKER_HALF_CYCLES,
	parameter int SELFTEST_LEN = SELFTEST_CYCLES
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	input wire mss_pkg::mss_pins_t pins,
	input wire logic [5:0] motor_current,
	output mss_pkg::mss_drive_t drive,
	output mss_pkg::mss_led_t led,
	output logic [NUM_GROUPS-1:0] safety_group_led
);
	import mss_pkg::*;

	localparam int FW = $clog2(FLICKER_HALF + 1);
	localparam int TW = $clog2(SELFTEST_LEN + 1);
	localparam int GW = $clog2(NUM_GROUPS);
	localparam int HW = $clog2(FLASH_FLICKER_HALVES + 1);

	if (NUM_GROUPS < 2 || NUM_GROUPS > 8) begin : g_bad_groups
		$error("NUM_GROUPS must be 2 to 8");
	end
	if (FLICKER_HALF < 2 || SELFTEST_LEN < 2) begin : g_bad_counts
		$error("divider counts must be at least 2");
	end

	typedef struct packed {
		mss_pins_t sync1;
		mss_pins_t sync2;
		logic [5:0] current;
		logic [7:0] out_img;
		mss_cfg_t cfg;
		logic [7:0] rdata;
		logic trip_prev;
		logic [FW-1:0] flick_cnt;
		logic flicker;
		logic [HW-1:0] flash_cnt;
		logic flash;
		logic [GW-1:0] run_pos;
		mss_mode_t mode;
		logic [TW-1:0] st_cnt;
		mss_drive_t drive;
		mss_led_t led;
		logic [NUM_GROUPS-1:0] sg;
	} mss_state_t;

	logic rst_meta;
	logic rst_sync;
	mss_state_t s;
	mss_state_t next_s;
	mss_pins_t p;
	mss_cfg_t c;
	logic lim_cw_act;
	logic lim_ccw_act;
	logic release_ok;
	logic mismatch;
	logic [NUM_GROUPS-1:0] run_light;

	// reset enters asynchronously, leaves synchronously
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end

	assign p = s.sync2;
	assign c = s.cfg;
	assign lim_cw_act = ~p.limit_cw_nc; // [R14]
	assign lim_ccw_act = ~p.limit_ccw_nc; // [R14]
	assign mismatch = c.group_configured && (c.group != p.sel_group);
	assign run_light = NUM_GROUPS'(1) << s.run_pos;

	// [R19] brake released only on command and when no limit or fault holds it
	assign release_ok = s.out_img[OUT_BRAKE] & ~lim_cw_act & ~lim_ccw_act // [R10] [R11]
		& ~p.brake_overload & (~p.bus_fault | c.bus_fault_release); // [R13]

	function automatic logic [7:0] read_mux(input mss_state_t st, input logic [3:0] a);
		logic [7:0] v;
		v = 8'h00;
		unique case (a)
			ADDR_IN0: begin
				v[IN0_READY] = ~(st.sync2.jammed | st.sync2.device_fault); // [R15]
				v[IN0_FEEDBACK] = st.sync2.fb_cw | st.sync2.fb_ccw; // [R16]
				v[IN0_BREAKER] = st.sync2.breaker_tripped; // [R17]
			end
			ADDR_IN1: begin
				if (st.cfg.high_feature) begin
					v[5:0] = st.current; // [R21]
					v[IN1_LOCAL] = st.sync2.local_manual; // [R20]
				end
			end
			ADDR_CFG: v = st.cfg;
			ADDR_STAT: begin
				v[STAT_SELFTEST] = (st.mode == MODE_SELFTEST);
				v[STAT_MISMATCH] = st.cfg.group_configured && (st.cfg.group != st.sync2.sel_group);
				v[STAT_DECODER] = st.sync2.decoder_fault;
			end
			default: v = 8'h00;
		endcase
		return v;
	endfunction : read_mux

	always_comb begin
		next_s = s;
		next_s.sync1 = pins;
		next_s.sync2 = s.sync1;
		next_s.current = motor_current; // [R21]

		// one divider chain keeps flash and flicker in phase
		if (s.flick_cnt == FW'(FLICKER_HALF - 1)) begin // [R22]
			next_s.flick_cnt = '0;
			next_s.flicker = ~s.flicker; // [R1]
			if (s.run_pos == GW'(NUM_GROUPS - 1)) begin
				next_s.run_pos = '0;
			end else begin
				next_s.run_pos = s.run_pos + GW'(1);
			end
			if (s.flash_cnt == HW'(FLASH_FLICKER_HALVES - 1)) begin
				next_s.flash_cnt = '0;
				next_s.flash = ~s.flash; // [R1]
			end else begin
				next_s.flash_cnt = s.flash_cnt + HW'(1);
			end
		end else begin
			next_s.flick_cnt = s.flick_cnt + FW'(1);
		end

		if (s.mode == MODE_SELFTEST) begin
			if (s.st_cnt == TW'(SELFTEST_LEN - 1)) begin
				next_s.mode = MODE_RUN;
			end else begin
				next_s.st_cnt = s.st_cnt + TW'(1);
			end
		end

		if (wr) begin
			if (addr == ADDR_OUT0) begin
				next_s.out_img = wdata;
			end else if (addr == ADDR_CFG) begin
				next_s.cfg = wdata;
			end
		end
		next_s.rdata = rd ? read_mux(s, addr) : 8'h00;

		// [R18] both directions at once is treated as stop
		next_s.drive.cw = s.out_img[OUT_CW] & ~s.out_img[OUT_CCW];
		next_s.drive.ccw = s.out_img[OUT_CCW] & ~s.out_img[OUT_CW];
		next_s.drive.brake_release = release_ok; // [R19]
		next_s.trip_prev = s.out_img[OUT_TRIP];
		next_s.drive.trip_reset = c.high_feature & s.out_img[OUT_TRIP] & ~s.trip_prev; // [R23]

		next_s.led.group_error_red = c.diag_en & (p.device_fault | p.jammed
			| p.brake_overload | p.bus_fault); // [R2] [R12] [R13]
		next_s.led.contactor_yellow = p.fb_cw | p.fb_ccw;
		// command without feedback: no current flow warning
		next_s.led.device_yellow = (s.out_img[OUT_CW] | s.out_img[OUT_CCW])
			& ~(p.fb_cw | p.fb_ccw) & s.flash;
		next_s.led.brake_yellow = p.brake_overload | release_ok; // [R9] [R12]
		next_s.led.limit_cw_green = ~lim_cw_act; // [R10]
		next_s.led.limit_ccw_green = ~lim_ccw_act; // [R11]

		for (int i = 0; i < NUM_GROUPS; i++) begin
			if (p.decoder_fault) begin
				next_s.sg[i] = run_light[i]; // [R8]
			end else if (mismatch) begin
				next_s.sg[i] = (p.sel_group == 3'(i) || c.group == 3'(i)) & s.flash; // [R7]
			end else if (p.sel_group == 3'(i)) begin
				if (p.estop && !c.group_configured) begin
					next_s.sg[i] = 1'b0; // [R3]
				end else if (!p.estop && c.group_configured) begin
					next_s.sg[i] = 1'b1; // [R5]
				end else begin
					next_s.sg[i] = s.flash; // [R4]
				end
			end else begin
				next_s.sg[i] = 1'b0;
			end
		end

		// older hardware keeps the live display during self test
		if (s.mode == MODE_SELFTEST && c.newer_hw) begin
			next_s.led.group_error_red = 1'b1; // [R6]
			next_s.led.contactor_yellow = 1'b1; // [R6]
			next_s.led.device_yellow = 1'b1; // [R6]
			next_s.sg = run_light; // [R6]
		end
	end

	always_ff @(posedge clock or negedge rst_sync) begin
		if (!rst_sync) begin
			s <= '{cfg: CFG_RESET, mode: MODE_SELFTEST, default: '0};
		end else begin
			s <= next_s;
		end
	end

	assign rdata = s.rdata;
	assign drive = s.drive;
	assign led = s.led;
	assign safety_group_led = s.sg;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_sync);

	flash_phase_a: assert property ( // [R1]
		$changed(s.flash) |-> $changed(s.flicker) && s.flash_cnt == '0)
		else $error("flash moved off a flicker edge");

	flicker_period_a: assert property ( // [R22]
		$changed(s.flicker) |-> s.flick_cnt == '0 && $past(s.flick_cnt) == FW'(FLICKER_HALF - 1))
		else $error("flicker half period wrong");

	diag_gate_a: assert property ( // [R2]
		s.mode == MODE_RUN && !c.diag_en |=> !led.group_error_red)
		else $error("group error lit with diagnostics off");

	sg_dark_a: assert property ( // [R3]
		!p.decoder_fault && !mismatch && p.estop && !c.group_configured
		&& int'(p.sel_group) < NUM_GROUPS && s.mode == MODE_RUN
		|=> safety_group_led == '0)
		else $error("safety group lit while unconfigured under stop");

	sg_steady_a: assert property ( // [R5]
		s.mode == MODE_RUN && !p.decoder_fault && !mismatch && !p.estop
		&& c.group_configured && int'(c.group) < NUM_GROUPS
		|=> safety_group_led == (NUM_GROUPS'(1) << $past(c.group)))
		else $error("configured group not steady green");

	mismatch_a: assert property ( // [R7]
		s.mode == MODE_RUN && !p.decoder_fault && mismatch && s.flash
		&& int'(p.sel_group) < NUM_GROUPS && int'(c.group) < NUM_GROUPS
		|=> $countones(safety_group_led) == 2)
		else $error("mismatch does not flash two groups");

	selftest_a: assert property ( // [R6]
		s.mode == MODE_SELFTEST && c.newer_hw
		|=> led.group_error_red && led.contactor_yellow && led.device_yellow
		&& $onehot(safety_group_led))
		else $error("self test display wrong");

	trip_edge_a: assert property ( // [R23]
		drive.trip_reset |=> !drive.trip_reset)
		else $error("trip reset repeated on held level");

	limit_brake_a: assert property ( // [R10]
		!p.limit_cw_nc |=> !drive.brake_release && !led.limit_cw_green)
		else $error("clockwise limit did not hold brake");

	ready_bit_a: assert property ( // [R15]
		rd && addr == ADDR_IN0 && p.jammed |=> rdata[IN0_READY] == 1'b0)
		else $error("ready bit set while jammed");

	sg_flash_a: assert property ( // [R4]
		s.mode == MODE_RUN && !p.decoder_fault && !mismatch
		&& p.estop == c.group_configured && int'(p.sel_group) < NUM_GROUPS
		|=> safety_group_led == (NUM_GROUPS'($past(s.flash)) << $past(p.sel_group)))
		else $error("safety group not flashing");

	decoder_light_a: assert property ( // [R8]
		s.mode == MODE_RUN && p.decoder_fault |=> $onehot(safety_group_led))
		else $error("decoder fault without running light");

	run_step_a: assert property ( // [R8]
		$changed(s.flicker) |-> s.run_pos != $past(s.run_pos))
		else $error("running light did not step");

	brake_led_a: assert property ( // [R9]
		!p.brake_overload |=> led.brake_yellow == drive.brake_release)
		else $error("brake indicator disagrees with brake");

	limit_ccw_a: assert property ( // [R11]
		!p.limit_ccw_nc |=> !drive.brake_release && !led.limit_ccw_green)
		else $error("counter-clockwise limit did not hold brake");

	limit_idle_a: assert property ( // [R14]
		p.limit_cw_nc && p.limit_ccw_nc |=> led.limit_cw_green && led.limit_ccw_green)
		else $error("closed limit contacts not shown green");

	overload_a: assert property ( // [R12]
		p.brake_overload && c.diag_en |=> led.group_error_red && led.brake_yellow)
		else $error("brake overload not shown");

	bus_fault_a: assert property ( // [R13]
		p.bus_fault && c.diag_en |=> led.group_error_red)
		else $error("bus fault not shown");

	bus_hold_a: assert property ( // [R13]
		p.bus_fault && !c.bus_fault_release |=> !drive.brake_release)
		else $error("brake released during bus fault");

	brake_cmd_a: assert property ( // [R19]
		!s.out_img[OUT_BRAKE] |=> !drive.brake_release)
		else $error("brake released without command");

	feedback_a: assert property ( // [R16]
		rd && addr == ADDR_IN0 |=> rdata[IN0_FEEDBACK] == $past(p.fb_cw || p.fb_ccw))
		else $error("contactor feedback bit wrong");

	breaker_a: assert property ( // [R17]
		rd && addr == ADDR_IN0
		|=> rdata[IN0_BREAKER] == $past(p.breaker_tripped) && rdata[7:3] == 5'h00)
		else $error("breaker bit or unused bits wrong");

	local_mode_a: assert property ( // [R20]
		rd && addr == ADDR_IN1 && c.high_feature
		|=> rdata[IN1_LOCAL] == $past(p.local_manual) && !rdata[7])
		else $error("local manual bit wrong");

	current_a: assert property ( // [R21]
		rd && addr == ADDR_IN1 && c.high_feature |=> rdata[5:0] == $past(s.current))
		else $error("motor current field wrong");

	rdata_idle_a: assert property (
		!rd |=> rdata == 8'h00)
		else $error("read data outside a read");

	interlock_a: assert property ( // [R18]
		!(drive.cw && drive.ccw))
		else $error("both directions driven");

	trip_gate_a: assert property ( // [R23]
		!c.high_feature |=> !drive.trip_reset)
		else $error("trip reset on standard starter");

	flash_range_a: assert property ( // [R1]
		s.flash_cnt <= HW'(FLASH_FLICKER_HALVES - 1) && s.flick_cnt <= FW'(FLICKER_HALF - 1))
		else $error("blink divider out of range");

	selftest_once_a: assert property ( // [R6]
		s.mode == MODE_RUN |=> s.mode == MODE_RUN)
		else $error("self test restarted without reset");

endmodule : mss_starter

`default_nettype wire

// file: shared/mss_pkg.sv
// motor starter status package: register map, field layouts, timing constants
// assumes a single 20 MHz system clock shared by all users of this package
package mss_pkg;

	// register offsets on the plain register port
	localparam logic [3:0] ADDR_IN0 = 4'h0;
	localparam logic [3:0] ADDR_OUT0 = 4'h1;
	localparam logic [3:0] ADDR_IN1 = 4'h2;
	localparam logic [3:0] ADDR_CFG = 4'h3;
	localparam logic [3:0] ADDR_STAT = 4'h4;

	// output image byte 0 bit positions
	localparam int OUT_CW = 0;
	localparam int OUT_CCW = 1;
	localparam int OUT_BRAKE = 2;
	localparam int OUT_TRIP = 3;

	// input image bit positions
	localparam int IN0_READY = 0;
	localparam int IN0_FEEDBACK = 1;
	localparam int IN0_BREAKER = 2;
	localparam int IN1_LOCAL = 6;

	// status register bit positions
	localparam int STAT_SELFTEST = 0;
	localparam int STAT_MISMATCH = 1;
	localparam int STAT_DECODER = 2;

	// timing
	localparam int CLOCK_HZ = 20_000_000;
	localparam int FLICKER_HZ = 9;
	localparam int FLASH_MILLIHZ = 500;
	localparam int SELFTEST_MS = 2000;
	localparam int FLICKER_HALF_CYCLES = CLOCK_HZ / (2 * FLICKER_HZ);
	localparam int FLASH_FLICKER_HALVES = (FLICKER_HZ * 1000) / FLASH_MILLIHZ;
	localparam int SELFTEST_CYCLES = SELFTEST_MS * (CLOCK_HZ / 1000);

	typedef struct packed {
		logic high_feature;
		logic [2:0] group;
		logic newer_hw;
		logic bus_fault_release;
		logic group_configured;
		logic diag_en;
	} mss_cfg_t;

	localparam mss_cfg_t CFG_RESET = 8'h01;

	typedef struct packed {
		logic estop;
		logic decoder_fault;
		logic device_fault;
		logic jammed;
		logic fb_cw;
		logic fb_ccw;
		logic breaker_tripped;
		logic local_manual;
		logic brake_overload;
		logic bus_fault;
		logic limit_cw_nc;
		logic limit_ccw_nc;
		logic [2:0] sel_group;
	} mss_pins_t;

	typedef struct packed {
		logic group_error_red;
		logic contactor_yellow;
		logic device_yellow;
		logic brake_yellow;
		logic limit_cw_green;
		logic limit_ccw_green;
	} mss_led_t;

	typedef struct packed {
		logic cw;
		logic ccw;
		logic brake_release;
		logic trip_reset;
	} mss_drive_t;

	typedef enum logic {
		MODE_SELFTEST = 1'b0,
		MODE_RUN = 1'b1
	} mss_mode_t;

endpackage : mss_pkg

// file: tb/mss_plc.sv
// controller model: master of the register port, writes output image, reads input image
// assumes the starter answers a read in the next cycle and never stalls
`timescale 1ns/1ns
`default_nettype none

module mss_plc (
	input wire logic clock,
	output logic [3:0] addr,
	output logic [7:0] wdata,
	output logic wr,
	output logic rd
);
	initial begin
		addr = 4'h0;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
	end

	// output image bits: run commands, brake release, trip edge
	task automatic write(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
		// released lines carry the inverse so stale values never match by luck
		addr <= ~a;
		wdata <= ~d;
	endtask : write

	task automatic read(input logic [3:0] a);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		addr <= ~a;
	endtask : read
endmodule : mss_plc

`default_nettype wire

// file: tb/testbench.sv
// top bench: controller model on the register port, pins and current driven here
// assumes shortened blink and self-test counts given to the starter below
`timescale 1ns/1ns
`default_nettype none

module testbench;
	import mss_pkg::*;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic [3:0] addr;
	logic [7:0] wdata;
	logic wr;
	logic rd;
	logic [7:0] rdata;
	mss_pins_t pins;
	logic [5:0] motor_current;
	mss_drive_t drive;
	mss_led_t led;
	logic [3:0] sg_led;
	logic [7:0] exp_q[$];
	logic rd_q = 1'b0;
	int mismatches = 0;
	int n_compared = 0;

	always #25 clock = ~clock;

	mss_plc i_plc (.clock(clock), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));

	mss_starter #(.NUM_GROUPS(4), .FLICKER_HALF(4), .SELFTEST_LEN(20)) i_dut (
		.clock(clock), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .pins(pins), .motor_current(motor_current), .drive(drive),
		.led(led), .safety_group_led(sg_led));

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic results();
		// a read still owed its answer counts against the run
		if (exp_q.size() != 0) mismatches++;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : results

	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
	endtask : cyc

	task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
		exp_q.push_back(exp);
		i_plc.read(a);
	endtask : rd_chk

	task automatic trips(output int n);
		n = 0;
		repeat (8) begin
			cyc(1);
			if (drive.trip_reset === 1'b1) n++;
		end
	endtask : trips

	task automatic count_sg(input logic [3:0] pat, input int n, output int k);
		k = 0;
		repeat (n) begin
			cyc(1);
			if (sg_led === pat) k++;
		end
	endtask : count_sg

	// one flicker half period later the light must have moved one group up
	task automatic rot_chk();
		logic [3:0] w;
		w = sg_led;
		cyc(4);
		chk("running light", {4'h0, w[2:0], w[3]}, {4'h0, sg_led});
	endtask : rot_chk

	// read data stand only in the cycle after the strobe
	always @(posedge clock) begin
		if (rd_q && exp_q.size() > 0) chk("rdata", exp_q.pop_front(), rdata);
		rd_q <= rd;
	end

	initial begin
		cyc(20000);
		mismatches++;
		results();
	end

	initial begin
		logic [7:0] v;
		int t;
		pins = '{limit_cw_nc: 1'b1, limit_ccw_nc: 1'b1, default: '0};
		motor_current = 6'h00;
		void'($urandom(32'h2c4bc220));
		cyc(2);
		rst_b <= 1'b1;
		cyc(30);
		rd_chk(ADDR_CFG, 8'h01);
		rd_chk(ADDR_OUT0, 8'h00);
		rd_chk(4'hF, 8'h00);
		// rail 0 unconfigured, no stop: flashing, measure one half period
		v[0] = sg_led[0];
		t = 0;
		while (sg_led[0] === v[0] && t < 200) begin
			cyc(1);
			t++;
		end
		v[0] = sg_led[0];
		t = 0;
		while (sg_led[0] === v[0] && t < 200) begin
			cyc(1);
			t++;
		end
		chk("flash half period", 8'h48, 8'(t));
		i_plc.write(ADDR_CFG, 8'h03);
		cyc(6);
		t = 0;
		repeat (100) begin
			cyc(1);
			if (sg_led[0] === 1'b1) t++;
		end
		chk("steady green", 8'h64, 8'(t));
		i_plc.write(ADDR_CFG, 8'h81);
		for (int i = 0; i < 8; i++) begin
			v = 8'($urandom());
			pins.jammed <= v[0];
			pins.device_fault <= v[1];
			pins.fb_cw <= v[2];
			pins.fb_ccw <= v[3];
			pins.breaker_tripped <= v[4];
			pins.local_manual <= v[5];
			motor_current <= 6'($urandom());
			cyc(5);
			rd_chk(ADDR_IN0, {5'h00, v[4], v[2] | v[3], ~(v[0] | v[1])});
			rd_chk(ADDR_IN1, {1'b0, v[5], motor_current});
		end
		pins <= '{limit_cw_nc: 1'b1, limit_ccw_nc: 1'b1, default: '0};
		i_plc.write(ADDR_OUT0, 8'h05);
		cyc(6);
		chk("drive", 8'h0A, 8'(drive));
		chk("brake led", 8'h01, 8'(led.brake_yellow));
		pins.limit_cw_nc <= 1'b0;
		cyc(6);
		chk("cw limit", 8'h04, {4'h0, led.limit_cw_green, led.limit_ccw_green,
			led.brake_yellow, drive.brake_release});
		pins.limit_cw_nc <= 1'b1;
		pins.limit_ccw_nc <= 1'b0;
		cyc(6);
		chk("ccw limit", 8'h08, {4'h0, led.limit_cw_green, led.limit_ccw_green,
			led.brake_yellow, drive.brake_release});
		pins.limit_ccw_nc <= 1'b1;
		pins.brake_overload <= 1'b1;
		cyc(6);
		chk("overload", 8'h03, {6'h00, led.group_error_red, led.brake_yellow});
		pins.brake_overload <= 1'b0;
		pins.bus_fault <= 1'b1;
		cyc(6);
		chk("bus fault", 8'h04, {5'h00, led.group_error_red, led.brake_yellow,
			drive.brake_release});
		i_plc.write(ADDR_CFG, 8'h85);
		cyc(6);
		chk("bus fault release", 8'h07, {5'h00, led.group_error_red, led.brake_yellow,
			drive.brake_release});
		i_plc.write(ADDR_CFG, 8'h80);
		cyc(6);
		chk("diag off", 8'h00, 8'(led.group_error_red));
		pins.bus_fault <= 1'b0;
		i_plc.write(ADDR_OUT0, 8'h08);
		trips(t);
		chk("trip on edge", 8'h01, 8'(t));
		i_plc.write(ADDR_OUT0, 8'h08);
		trips(t);
		chk("trip held", 8'h00, 8'(t));
		// second reset in mid-run; newer hardware selected while self test runs
		rst_b <= 1'b0;
		pins <= '{limit_cw_nc: 1'b1, limit_ccw_nc: 1'b1, default: '0};
		cyc(2);
		rst_b <= 1'b1;
		cyc(2);
		i_plc.write(ADDR_CFG, 8'h09);
		cyc(2);
		chk("self test", 8'h0F, {4'h0, led.group_error_red, led.contactor_yellow,
			led.device_yellow, 1'($onehot(sg_led))});
		rot_chk();
		rd_chk(ADDR_STAT, 8'h01);
		cyc(16);
		pins <= '{estop: 1'b1, sel_group: 3'h1, limit_cw_nc: 1'b1,
			limit_ccw_nc: 1'b1, default: '0};
		cyc(4);
		count_sg(4'h0, 144, t);
		chk("stop unconfigured", 8'h90, 8'(t));
		i_plc.write(ADDR_CFG, 8'h13);
		cyc(2);
		count_sg(4'h2, 144, t);
		chk("stop configured", 8'h48, 8'(t));
		i_plc.write(ADDR_CFG, 8'h23);
		cyc(2);
		count_sg(4'h6, 144, t);
		chk("mismatch", 8'h48, 8'(t));
		rd_chk(ADDR_STAT, 8'h02);
		pins.decoder_fault <= 1'b1;
		cyc(4);
		chk("decoder light", 8'h01, 8'($onehot(sg_led)));
		rot_chk();
		cyc(4);
		results();
	end
endmodule : testbench

`default_nettype wire
